/* File: shared/i2csc_defines.vh */
// Constants for the I2C start-condition control block.
`ifndef I2CSC_DEFINES_VH
`define I2CSC_DEFINES_VH

// Register byte offsets.
`define I2CSC_OFF_CTRL 12'h000
`define I2CSC_OFF_FLAG 12'h004
`define I2CSC_OFF_IRQ_STAT 12'h008
`define I2CSC_OFF_IRQ_MASK 12'h00C

// Control register bit positions.
`define I2CSC_CTRL_ENABLE 7
`define I2CSC_CTRL_EXIT 6
`define I2CSC_CTRL_ACK_EN 2
`define I2CSC_CTRL_START 1
`define I2CSC_CTRL_STOP 0

// Flag register bit positions.
`define I2CSC_FLAG_REFUSED 7
`define I2CSC_FLAG_BUSY 6
`define I2CSC_FLAG_RSV_DIS 0

// Interrupt status bit positions and width.
`define I2CSC_IRQ_DONE 0
`define I2CSC_IRQ_REFUSED 1
`define I2CSC_IRQ_ARB_LOST 2
`define I2CSC_IRQ_W 3

// Reset values.
`define I2CSC_RST_BYTE 8'h00
`define I2CSC_RST_IRQ 3'h0
`define I2CSC_RST_WORD 32'h0000_0000

// Timing.
`define I2CSC_CLK_NS 40
`define I2CSC_START_HOLD_NS 4000
`define I2CSC_RS_SETUP_NS 4700
// Cycle counts of the two times above at the clock period, sized for the 8-bit counter.
`define I2CSC_HOLD_CYC 8'h64
`define I2CSC_SETUP_CYC 8'h76
`define I2CSC_CNT_ZERO 8'h00
`define I2CSC_CNT_ONE 8'h01

`endif

/* File: core/i2csc_start_ctrl.v */
// Start-condition trigger control of an I2C controller with an APB register port.
`timescale 1ns/100ps
`include "i2csc_defines.vh"
module i2csc_start_ctrl
(
   // Clock and reset.
   input wire sys_clk,
   input wire sys_rst,
   // APB slave.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // I2C pins, open drain.
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   // Byte engine status, same clock.
   input wire addr_phase,
   input wire ext_code,
   input wire slave_addr_match,
   input wire ack_slot,
   // Interrupt.
   output reg irq
);

   localparam [4:0] ST_IDLE = 5'b00001;
   localparam [4:0] ST_START = 5'b00010;
   localparam [4:0] ST_WAIT = 5'b00100;
   localparam [4:0] ST_RS_REL = 5'b01000;
   localparam [4:0] ST_RS_SCL = 5'b10000;
   localparam [7:0] HOLD_CYC = `I2CSC_HOLD_CYC;
   localparam [7:0] SETUP_CYC = `I2CSC_SETUP_CYC;

   reg scl_m;
   reg scl_s;
   reg sda_m;
   reg sda_s;
   reg scl_d;
   reg sda_d;
   reg [4:0] state;
   reg [7:0] cnt;
   reg ctrl_enable;
   reg ack_enable;
   reg start_trigger;
   reg reservation_disable;
   reg start_refused_flag;
   reg bus_busy;
   reg [`I2CSC_IRQ_W-1:0] irq_stat;
   reg [`I2CSC_IRQ_W-1:0] irq_mask;
   reg ack_drive;
   reg [4:0] next_state;
   reg [7:0] next_cnt;
   reg next_trigger_clr;
   reg next_done;
   reg next_refused;
   reg next_arb_lost;
   reg next_scl_oe;
   reg next_sda_oe;
   reg [31:0] next_rdata;
   reg next_slverr;
   wire acc;
   wire wr;
   wire wr_ctrl;
   wire wr_exit;
   wire wr_start;
   wire bus_start;
   wire bus_stop;
   wire cnt_done;
   wire [`I2CSC_IRQ_W-1:0] irq_events;

   assign acc = psel & penable & pready;
   assign wr = acc & pwrite;
   assign wr_ctrl = wr & (paddr == `I2CSC_OFF_CTRL);
   assign wr_exit = wr_ctrl & pwdata[`I2CSC_CTRL_EXIT];
   assign wr_start = wr_ctrl & pwdata[`I2CSC_CTRL_START] & pwdata[`I2CSC_CTRL_ENABLE];
   assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
   assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;
   assign cnt_done = (cnt == `I2CSC_CNT_ZERO);
   assign irq_events = {next_arb_lost, next_refused, next_done} &
      {`I2CSC_IRQ_W{ctrl_enable & ~wr_exit}};

   // Pin synchronisers and edge history.
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         sda_m <= sda_in;
         sda_s <= sda_m;
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // Start sequencer.
   always @*
   begin
      next_state = state;
      next_cnt = cnt;
      next_trigger_clr = 1'b0;
      next_done = 1'b0;
      next_refused = 1'b0;
      next_arb_lost = 1'b0;
      next_scl_oe = scl_oe;
      next_sda_oe = 1'b0;
      case (state)
         ST_IDLE:
         begin
            next_scl_oe = 1'b0;
            next_sda_oe = ack_drive;
            if (start_trigger & ~bus_busy & scl_s & sda_s)
            begin
               next_state = ST_START;
               next_sda_oe = 1'b1;
               next_cnt = HOLD_CYC - `I2CSC_CNT_ONE;
            end
            else if (start_trigger & bus_busy & reservation_disable)
            begin
               next_trigger_clr = 1'b1;
               next_refused = 1'b1;
            end
         end
         ST_START:
         begin
            next_sda_oe = 1'b1;
            if (~scl_s)
            begin
               next_state = ST_IDLE;
               next_trigger_clr = 1'b1;
               next_arb_lost = 1'b1;
               next_sda_oe = 1'b0;
            end
            else if (cnt_done)
            begin
               next_state = ST_WAIT;
               next_scl_oe = 1'b1;
               next_trigger_clr = 1'b1;
               next_done = 1'b1;
            end
            else
               next_cnt = cnt - `I2CSC_CNT_ONE;
         end
         ST_WAIT:
         begin
            next_scl_oe = 1'b1;
            next_sda_oe = 1'b1;
            if (start_trigger)
            begin
               next_state = ST_RS_REL;
               next_sda_oe = 1'b0;
               next_cnt = SETUP_CYC - `I2CSC_CNT_ONE;
            end
         end
         ST_RS_REL:
         begin
            next_scl_oe = 1'b1;
            if (cnt_done)
            begin
               next_state = ST_RS_SCL;
               next_scl_oe = 1'b0;
               next_cnt = SETUP_CYC - `I2CSC_CNT_ONE;
            end
            else
               next_cnt = cnt - `I2CSC_CNT_ONE;
         end
         ST_RS_SCL:
         begin
            next_scl_oe = 1'b0;
            if (scl_s & ~sda_s)
            begin
               next_state = ST_IDLE;
               next_trigger_clr = 1'b1;
               next_arb_lost = 1'b1;
            end
            else if (~scl_s)
               next_cnt = SETUP_CYC - `I2CSC_CNT_ONE;
            else if (cnt_done)
            begin
               next_state = ST_START;
               next_sda_oe = 1'b1;
               next_cnt = HOLD_CYC - `I2CSC_CNT_ONE;
            end
            else
               next_cnt = cnt - `I2CSC_CNT_ONE;
         end
         default:
         begin
            next_state = ST_IDLE;
            next_scl_oe = 1'b0;
         end
      endcase
   end

   // State, pins and trigger.
   always @(posedge sys_clk)
   begin
      if (sys_rst | ~ctrl_enable | wr_exit)
      begin
         state <= ST_IDLE;
         cnt <= `I2CSC_CNT_ZERO;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         start_trigger <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         scl_oe <= next_scl_oe;
         sda_oe <= next_sda_oe;
         if (wr_start & ~pwdata[`I2CSC_CTRL_EXIT])
            start_trigger <= 1'b1;
         else if (next_trigger_clr)
            start_trigger <= 1'b0;
      end
   end

   // Bus busy tracking and acknowledge drive.
   always @(posedge sys_clk)
   begin
      if (sys_rst | ~ctrl_enable)
      begin
         bus_busy <= 1'b0;
         ack_drive <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
      else
      begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         if (bus_start)
            bus_busy <= 1'b1;
         else if (bus_stop)
            bus_busy <= 1'b0;
         ack_drive <= ack_slot & (slave_addr_match | (ack_enable & ~addr_phase & ext_code));
      end
   end

   // Control and flag registers.
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ctrl_enable <= 1'b0;
         ack_enable <= 1'b0;
         reservation_disable <= 1'b0;
         start_refused_flag <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_enable <= pwdata[`I2CSC_CTRL_ENABLE];
            ack_enable <= pwdata[`I2CSC_CTRL_ACK_EN];
         end
         if (wr & (paddr == `I2CSC_OFF_FLAG))
            reservation_disable <= pwdata[`I2CSC_FLAG_RSV_DIS];
         if (next_refused & ctrl_enable & ~wr_exit)
            start_refused_flag <= 1'b1;
         else if (wr_start | ~ctrl_enable)
            start_refused_flag <= 1'b0;
      end
   end

   // Interrupt status and mask.
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         irq_stat <= `I2CSC_RST_IRQ;
         irq_mask <= `I2CSC_RST_IRQ;
         irq <= 1'b0;
      end
      else
      begin
         if (wr & (paddr == `I2CSC_OFF_IRQ_STAT))
            irq_stat <= (irq_stat & ~pwdata[`I2CSC_IRQ_W-1:0]) | irq_events;
         else
            irq_stat <= irq_stat | irq_events;
         if (wr & (paddr == `I2CSC_OFF_IRQ_MASK))
            irq_mask <= pwdata[`I2CSC_IRQ_W-1:0];
         irq <= |(irq_stat & irq_mask);
      end
   end

   // Read mux.
   always @*
   begin
      next_rdata = `I2CSC_RST_WORD;
      next_slverr = 1'b0;
      case (paddr)
         `I2CSC_OFF_CTRL:
         begin
            next_rdata[`I2CSC_CTRL_ENABLE] = ctrl_enable;
            next_rdata[`I2CSC_CTRL_ACK_EN] = ack_enable;
            next_rdata[`I2CSC_CTRL_START] = 1'b0;
         end
         `I2CSC_OFF_FLAG:
         begin
            next_rdata[`I2CSC_FLAG_REFUSED] = start_refused_flag;
            next_rdata[`I2CSC_FLAG_BUSY] = bus_busy;
            next_rdata[`I2CSC_FLAG_RSV_DIS] = reservation_disable;
         end
         `I2CSC_OFF_IRQ_STAT:
            next_rdata[`I2CSC_IRQ_W-1:0] = irq_stat;
         `I2CSC_OFF_IRQ_MASK:
            next_rdata[`I2CSC_IRQ_W-1:0] = irq_mask;
         default:
            next_slverr = 1'b1;
      endcase
   end

   // APB answer with one wait state.
   always @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `I2CSC_RST_WORD;
      end
      else
      begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & next_slverr;
         prdata <= (psel & penable & ~pready & ~pwrite) ? next_rdata : `I2CSC_RST_WORD;
      end
   end

endmodule // i2csc_start_ctrl

/* File: tb/i2csc_start_props.sv */
// Port checker for the start-condition control block.
`timescale 1ns/100ps
module i2csc_start_props
(
   // Clock and reset.
   input wire sys_clk,
   input wire sys_rst,
   // APB.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Pins and interrupt.
   input wire scl_oe,
   input wire sda_oe,
   input wire irq
);
   logic [7:0] hold_cnt;
   logic [7:0] since_wr;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Counts data-low cycles with the clock free, and cycles since the last write.
   always @(posedge sys_clk)
   begin
      hold_cnt <= (sys_rst || !sda_oe || scl_oe) ? 8'h00 : hold_cnt + 8'h01;
      since_wr <= sys_rst ? 8'hFF : (pready && pwrite) ? 8'h00 :
         since_wr + {7'h00, since_wr != 8'hFF};
   end
   sequence s_access;
      psel && penable && !pready ##1 pready;
   endsequence
   a_apb_wait: assert property (psel && !penable |=> s_access)
      else $error("access not answered after one wait cycle");
   a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("slave error outside the answer cycle");
   a_trig_reads0: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[1:0] == 2'h0)
      else $error("trigger bits read back set");
   a_reset_idle: assert property ($fell(sys_rst) |-> !scl_oe && !sda_oe && !irq && !pready)
      else $error("lines or outputs active after reset");
   a_start_keep: assert property ($rose(sda_oe) && !scl_oe |=> !scl_oe [*8])
      else $error("clock pulled too early after data low");
   a_start_hold: assert property ($rose(scl_oe) |-> sda_oe && hold_cnt == 8'h64)
      else $error("clock pulled low without the start hold");
   a_clk_release: assert property ($fell(scl_oe) |-> !sda_oe && since_wr < 8'h90)
      else $error("clock released without a command");
   a_irq_masked: assert property (pready && pwrite && paddr == 12'h00C && pwdata[2:0] == 3'h0 |=> ##1 !irq)
      else $error("interrupt high with all sources masked");
endmodule // i2csc_start_props

/* File: tb/i2csc_bus_peer.sv */
// Model of another master framing traffic on the shared bus.
`timescale 1ns/100ps
module i2csc_bus_peer
(
   // Frame request from the bench.
   input wire frame,
   // Pull-low enables onto the open-drain lines.
   output logic scl_pull,
   output logic sda_pull
);
   initial
   begin
      scl_pull = 1'h0;
      sda_pull = 1'h0;
      forever
      begin
         wait (frame);
         // Keeps every line change off the block's sampling edge.
         #10;
         sda_pull = 1'h1;
         #160;
         // The clock runs at 320 ns only inside a frame.
         while (frame)
         begin
            scl_pull = 1'h1;
            #160 scl_pull = 1'h0;
            #160;
         end
         #160 sda_pull = 1'h0;
         #160;
      end
   end
endmodule // i2csc_bus_peer

/* File: tb/i2csc_start_ctrl_tb.sv */
// Testbench of the start-condition control block.
`timescale 1ns/100ps
`include "i2csc_defines.vh"
module i2csc_start_ctrl_tb;
   logic sys_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic addr_phase = 1'h0;
   logic ext_code = 1'h0;
   logic slave_addr_match = 1'h0;
   logic ack_slot = 1'h0;
   logic frame = 1'h0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, scl_pull, sda_pull, rerr;
   int n_mismatch = 0;
   int n_checks = 0;
   int c;
   logic [4:0] ack_tab [4] = '{5'h15, 5'h0E, 5'h08, 5'h0B};
   wire scl_w = !(scl_oe || scl_pull);
   wire sda_w = !(sda_oe || sda_pull);
   always #20 sys_clk = !sys_clk;
   i2csc_start_ctrl i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe), .addr_phase(addr_phase), .ext_code(ext_code),
      .slave_addr_match(slave_addr_match), .ack_slot(ack_slot), .irq(irq));
   i2csc_bus_peer i_peer (.frame(frame), .scl_pull(scl_pull), .sda_pull(sda_pull));
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      begin
         n_checks++;
         if (seen !== exp)
         begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      begin
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge sys_clk);
         penable <= 1'h1;
         @(posedge sys_clk);
         while (pready !== 1'h1)
            @(posedge sys_clk);
         rdat = prdata;
         rerr = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
         @(posedge sys_clk);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      begin
         apb(1'h0, a, 32'h0000_0000);
         chk($sformatf("reg %h", a), rdat, e);
      end
   endtask
   task wt(input int s, input logic v, input int lim);
      begin
         c = 0;
         while ((s == 0 ? sda_oe : scl_oe) !== v && c < lim)
         begin
            @(posedge sys_clk);
            c++;
         end
      end
   endtask
   initial
   begin
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'h0;
      @(posedge sys_clk);
      rd(`I2CSC_OFF_CTRL, 32'h0000_0000);
      rd(`I2CSC_OFF_FLAG, 32'h0000_0000);
      rd(`I2CSC_OFF_IRQ_STAT, 32'h0000_0000);
      rd(`I2CSC_OFF_IRQ_MASK, 32'h0000_0000);
      rd(12'h010, 32'h0000_0000);
      chk("slave error", rerr, 1'h1);
      wr(`I2CSC_OFF_CTRL, 32'h0000_0002);
      wt(0, 1'h1, 150);
      chk("start while off", sda_oe, 1'h0);
      foreach (ack_tab[i])
      begin
         wr(`I2CSC_OFF_CTRL, {24'h00_0000, 5'h10, ack_tab[i][3], 2'h0});
         slave_addr_match <= ack_tab[i][4];
         addr_phase <= ack_tab[i][2];
         ext_code <= ack_tab[i][1];
         ack_slot <= 1'h1;
         repeat (4) @(posedge sys_clk);
         chk("ack drive", sda_oe, ack_tab[i][0]);
         ack_slot <= 1'h0;
         repeat (4) @(posedge sys_clk);
      end
      wr(`I2CSC_OFF_IRQ_MASK, 32'h0000_0007);
      wr(`I2CSC_OFF_CTRL, 32'h0000_0082);
      rd(`I2CSC_OFF_CTRL, 32'h0000_0080);
      wt(0, 1'h1, 20);
      chk("clock at start", {sda_oe, scl_oe}, 2'h2);
      chk("open drain levels", {sda_out, scl_out}, 2'h0);
      wt(1, 1'h1, 200);
      chk("hold cycles", c >= 97 && c <= 102, 1'h1);
      rd(`I2CSC_OFF_IRQ_STAT, 32'h0000_0001);
      chk("irq", irq, 1'h1);
      wr(`I2CSC_OFF_IRQ_STAT, 32'h0000_0007);
      repeat (2) @(posedge sys_clk);
      chk("irq clear", irq, 1'h0);
      wr(`I2CSC_OFF_CTRL, 32'h0000_0082);
      wt(0, 1'h0, 20);
      chk("data released", sda_oe, 1'h0);
      wt(0, 1'h1, 400);
      wt(1, 1'h1, 200);
      chk("repeated start", {sda_oe, scl_oe}, 2'h3);
      wr(`I2CSC_OFF_CTRL, 32'h0000_00C0);
      repeat (3) @(posedge sys_clk);
      chk("exit", {sda_oe, scl_oe}, 2'h0);
      wr(`I2CSC_OFF_CTRL, 32'h0000_0000);
      wr(`I2CSC_OFF_CTRL, 32'h0000_0080);
      wr(`I2CSC_OFF_IRQ_STAT, 32'h0000_0007);
      frame <= 1'h1;
      repeat (20) @(posedge sys_clk);
      wr(`I2CSC_OFF_FLAG, 32'h0000_0001);
      wr(`I2CSC_OFF_CTRL, 32'h0000_0082);
      rd(`I2CSC_OFF_FLAG, 32'h0000_00C1);
      rd(`I2CSC_OFF_IRQ_STAT, 32'h0000_0002);
      chk("refused start", sda_oe, 1'h0);
      wr(`I2CSC_OFF_FLAG, 32'h0000_0000);
      wr(`I2CSC_OFF_CTRL, 32'h0000_0082);
      repeat (20) @(posedge sys_clk);
      chk("held reservation", sda_oe, 1'h0);
      frame <= 1'h0;
      wt(0, 1'h1, 100);
      chk("reserved start", sda_oe, 1'h1);
      frame <= 1'h1;
      repeat (30) @(posedge sys_clk);
      chk("lost start", sda_oe, 1'h0);
      rd(`I2CSC_OFF_IRQ_STAT, 32'h0000_0006);
      wr(`I2CSC_OFF_IRQ_MASK, 32'h0000_0000);
      repeat (2) @(posedge sys_clk);
      chk("irq masked", irq, 1'h0);
      wr(`I2CSC_OFF_CTRL, 32'h0000_0082);
      wr(`I2CSC_OFF_CTRL, 32'h0000_0000);
      wr(`I2CSC_OFF_CTRL, 32'h0000_0080);
      frame <= 1'h0;
      wt(0, 1'h1, 100);
      chk("dropped reservation", sda_oe, 1'h0);
      print_verdict;
   end
   initial
   begin
      #800000;
      n_mismatch++;
      print_verdict;
   end
endmodule // i2csc_start_ctrl_tb
bind i2csc_start_ctrl i2csc_start_props i_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .scl_oe(scl_oe), .sda_oe(sda_oe), .irq(irq));
